// ===== src/ccp_consts.svh
// Purpose: constants for the capture/compare/pwm mode and output block
// Assumes: apb byte addresses, 32-bit data, registers in the low bits, 8 bits or fewer except the 16-bit compare and capture
// Notes:
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
`define ADDR_CONTROL 8'h00
`define ADDR_DUTY_HIGH 8'h04
`define ADDR_COMPARE 8'h08
`define ADDR_PIN_SELECT 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_MASK 8'h14
`define ADDR_CAPTURE 8'h18
`define ADDR_DEADBAND 8'h1c
`define CONTROL_RESET 8'h00
`define MODE_OFF 4'h0
`define MODE_RSV1 4'h1
`define MODE_TOGGLE 4'h2
`define MODE_RSV3 4'h3
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLR 4'h9
`define MODE_CMP_SOFT 4'ha
`define MODE_CMP_TRIG 4'hb
`define CFG_SINGLE 2'h0
`define CFG_FWD 2'h1
`define CFG_HALF 2'h2
`define CFG_REV 2'h3
`define PRESCALE_4 2'h3
`define PRESCALE_16 4'hf
`define DIR_BLANK_COUNTS 3'h4
`define ST_EVENT_BIT 0
`define ST_MATCH_BIT 1
`define ST_PERIOD_BIT 2
`define IRQ_BITS 3
`endif

// ===== src/ccp_pkg.sv
// Purpose: types for the capture/compare/pwm block
// Assumes: nothing
// Notes: one-hot state of the unit
package ccp_pkg;
   typedef enum logic [3:0] {
      st_off = 4'b0001,
      st_capture = 4'b0010,
      st_compare = 4'b0100,
      st_pwm = 4'b1000
   } unit_state_t;
endpackage

// ===== src/ccp_mode_output_config.sv
// Purpose: mode decode, capture/compare actions, pwm output routing, apb registers
// Assumes: timer and its period pulses come from outside; inputs synchronous to pclk
// Notes: dead-band delay, shutdown and steering are outside this block
`include "ccp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ccp_mode_output_config
   import ccp_pkg::*;
#(
   parameter bit ENHANCED = 1'b1,
   parameter int DUTY_W = 10,
   parameter int TIMER_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [TIMER_W-1:0] timer_value,
   input wire logic [DUTY_W-1:0] pwm_timer,
   input wire logic pwm_period_start,
   input wire logic unit_pin_in,
   input wire logic [3:0] port_out,
   input wire logic adc_enabled,
   output logic [3:0] out_level,
   output logic [3:0] out_owned,
   output logic [1:0] out_b_location,
   output logic [1:0] out_d_location,
   output logic timer_reset,
   output logic adc_start,
   output logic unit_event_flag,
   output logic irq
);
   logic [7:0] unit_mode_control;
   logic [7:0] duty_high_register;
   logic [TIMER_W-1:0] compare_value;
   logic [TIMER_W-1:0] capture_value;
   logic [2:0] pin_select;
   logic [`IRQ_BITS-1:0] status;
   logic [`IRQ_BITS-1:0] mask;
   logic [6:0] deadband_count;
   logic [3:0] unit_mode_field;
   logic [1:0] output_config_field;
   logic [1:0] duty_low_bits;
   logic [1:0] last_config;
   logic [DUTY_W-1:0] duty_value;
   logic [DUTY_W-1:0] duty_latched;
   unit_state_t state;
   logic pin_q;
   logic pin_prev;
   logic [3:0] edge_count;
   logic [2:0] blank_count;
   logic pwm_raw;
   logic match;
   logic capture_event;
   logic wr_en;
   logic rd_en;
   logic mode_write;
   logic [3:0] next_mode;
   logic [3:0] next_level;
   logic [3:0] next_owned;
   logic [DUTY_W-1:0] pwm_timer_prev;
   logic pwm_timer_step;
   logic unit_off;
   logic cmp_match;
   logic drives_compare_pin;

   function automatic logic is_pwm(input logic [3:0] m);
      is_pwm = m[3] & m[2];
   endfunction

   // plain units lose the config field and the trigger code; trigger falls back to soft
   function automatic logic [3:0] legal_mode(input logic [3:0] m);
      if (!ENHANCED && m == `MODE_CMP_TRIG) begin
         legal_mode = `MODE_CMP_SOFT;
      end else begin
         legal_mode = m;
      end
   endfunction

   assign unit_mode_field = unit_mode_control[3:0];
   assign output_config_field = ENHANCED ? unit_mode_control[7:6] : `CFG_SINGLE;
   // compare codes that own the unit pin; soft and trigger codes leave it to the port
   function automatic logic owns_compare_pin(input logic [3:0] m);
      owns_compare_pin = m == `MODE_TOGGLE || m == `MODE_CMP_SET || m == `MODE_CMP_CLR;
   endfunction

   assign duty_low_bits = unit_mode_control[5:4];
   assign duty_value = {duty_high_register, duty_low_bits};

   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   // read data loads in the setup cycle so it already stands at the access edge;
   // a zero-wait slave has no later cycle in which to present it
   assign rd_en = psel & ~penable & ~pwrite;
   assign pslverr = 1'b0;
   assign mode_write = wr_en && paddr == `ADDR_CONTROL;
   assign next_mode = legal_mode(pwdata[3:0]);
   assign irq = |(status & mask);
   assign unit_event_flag = status[`ST_EVENT_BIT];
   assign match = timer_value == compare_value;
   assign unit_off = state == st_off;
   // a match in the cycle of a mode write belongs to neither the old nor the new mode
   assign cmp_match = state == st_compare && match && !mode_write;
   assign drives_compare_pin = state == st_compare && owns_compare_pin(unit_mode_field);

   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_mode_control <= `CONTROL_RESET;
         duty_high_register <= 8'h00;
         compare_value <= '0;
         pin_select <= 3'h0;
         mask <= '0;
         deadband_count <= 7'h00;
      end else if (wr_en) begin
         unique case (paddr)
            `ADDR_CONTROL: unit_mode_control <= {pwdata[7:4], next_mode};
            `ADDR_DUTY_HIGH: duty_high_register <= pwdata[7:0];
            `ADDR_COMPARE: compare_value <= pwdata[TIMER_W-1:0];
            `ADDR_PIN_SELECT: pin_select <= pwdata[2:0];
            `ADDR_MASK: mask <= pwdata[`IRQ_BITS-1:0];
            `ADDR_DEADBAND: deadband_count <= pwdata[6:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_en) begin
         unique case (paddr)
            `ADDR_CONTROL: prdata <= {24'h0, unit_mode_control};
            `ADDR_DUTY_HIGH: prdata <= {24'h0, duty_high_register};
            `ADDR_COMPARE: prdata <= 32'(compare_value);
            `ADDR_PIN_SELECT: prdata <= {29'h0, pin_select};
            `ADDR_STATUS: prdata <= 32'(status);
            `ADDR_MASK: prdata <= 32'(mask);
            `ADDR_CAPTURE: prdata <= 32'(capture_value);
            `ADDR_DEADBAND: prdata <= {25'h0, deadband_count};
            default: prdata <= 32'h0;
         endcase
      end
   end

   // state follows the mode field; reserved codes are off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_off;
      end else begin
         unique casez (unit_mode_field)
            4'b0000, 4'b0001, 4'b0011: state <= st_off;
            4'b0010, 4'b10??: state <= st_compare;
            4'b01??: state <= st_capture;
            4'b11??: state <= st_pwm;
         endcase
      end
   end

   // capture edge detect and prescaler; prescaler restarts on any mode write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev <= 1'b0;
         edge_count <= 4'h0;
      end else begin
         pin_prev <= unit_pin_in;
         if (mode_write || state != st_capture) begin
            edge_count <= 4'h0;
         end else if (unit_pin_in & ~pin_prev && unit_mode_field[1]) begin
            edge_count <= edge_count + 4'h1;
         end
      end
   end

   // capture register; cleared while off so a time from before an off period never reads back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_value <= '0;
      end else if (unit_off) begin
         capture_value <= '0;
      end else if (capture_event) begin
         capture_value <= timer_value;
      end
   end

   always_comb begin
      capture_event = 1'b0;
      if (state == st_capture && !mode_write) begin
         unique case (unit_mode_field)
            `MODE_CAP_FALL: capture_event = ~unit_pin_in & pin_prev;
            `MODE_CAP_RISE: capture_event = unit_pin_in & ~pin_prev;
            `MODE_CAP_RISE4: capture_event = unit_pin_in & ~pin_prev
               && edge_count[1:0] == `PRESCALE_4;
            `MODE_CAP_RISE16: capture_event = unit_pin_in & ~pin_prev
               && edge_count == `PRESCALE_16;
            default: capture_event = 1'b0;
         endcase
      end
   end

   // compare pin and trigger outputs; writing a compare mode sets the initial pin level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
         timer_reset <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         timer_reset <= 1'b0;
         adc_start <= 1'b0;
         if (mode_write) begin
            if (next_mode == `MODE_CMP_SET) pin_q <= 1'b0;
            else if (next_mode == `MODE_CMP_CLR) pin_q <= 1'b1;
            else pin_q <= 1'b0;
         end else if (state == st_compare && match) begin
            unique case (unit_mode_field)
               `MODE_TOGGLE: pin_q <= ~pin_q;
               `MODE_CMP_SET: pin_q <= 1'b1;
               `MODE_CMP_CLR: pin_q <= 1'b0;
               `MODE_CMP_TRIG: begin
                  timer_reset <= 1'b1;
                  adc_start <= adc_enabled;
               end
               default: ;
            endcase
         end
      end
   end

   // sticky status, set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         logic [`IRQ_BITS-1:0] set_bits;
         set_bits = '0;
         set_bits[`ST_EVENT_BIT] = capture_event
            || (cmp_match && unit_mode_field[3]);
         set_bits[`ST_MATCH_BIT] = cmp_match;
         set_bits[`ST_PERIOD_BIT] = state == st_pwm && pwm_period_start;
         if (wr_en && paddr == `ADDR_STATUS) begin
            status <= (status & ~pwdata[`IRQ_BITS-1:0]) | set_bits;
         end else begin
            status <= status | set_bits;
         end
      end
   end

   // duty reloads each period; direction change blanks b and d for four counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_latched <= '0;
         last_config <= `CFG_SINGLE;
         blank_count <= 3'h0;
      end else begin
         if (state != st_pwm) begin
            // a fresh pwm start waits for its first period with the output inactive
            duty_latched <= '0;
            blank_count <= 3'h0;
            last_config <= output_config_field;
         end else begin
            if (pwm_period_start) begin
               duty_latched <= duty_value;
            end
            last_config <= output_config_field;
            if (output_config_field[0] && last_config[0]
                && output_config_field != last_config) begin
               blank_count <= `DIR_BLANK_COUNTS;
            end else if (blank_count != 3'h0 && pwm_timer_step) begin
               blank_count <= blank_count - 3'h1;
            end
         end
      end
   end

   // any change of the pwm counter counts as one timer count for blanking
   assign pwm_timer_step = pwm_timer != pwm_timer_prev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_timer_prev <= '0;
      end else begin
         pwm_timer_prev <= pwm_timer;
      end
   end

   assign pwm_raw = pwm_timer < duty_latched;

   // output routing: level is the active level after polarity; owned means unit drives
   always_comb begin
      logic pol_ac;
      logic pol_bd;
      pol_ac = ENHANCED ? unit_mode_field[1] : 1'b0;
      pol_bd = ENHANCED ? unit_mode_field[0] : 1'b0;
      next_level = port_out;
      next_owned = 4'b0000;
      unique case (state)
         st_pwm: begin
            unique case (output_config_field)
               `CFG_SINGLE: begin
                  next_owned = 4'b0001;
                  next_level[0] = pwm_raw ^ pol_ac;
               end
               `CFG_FWD: begin
                  next_owned = 4'b1111;
                  next_level[0] = 1'b1 ^ pol_ac;
                  next_level[1] = 1'b0 ^ pol_bd;
                  next_level[2] = 1'b0 ^ pol_ac;
                  next_level[3] = (pwm_raw && blank_count == 3'h0) ^ pol_bd;
               end
               `CFG_HALF: begin
                  next_owned = 4'b0011;
                  next_level[0] = pwm_raw ^ pol_ac;
                  next_level[1] = ~pwm_raw ^ pol_bd;
               end
               `CFG_REV: begin
                  next_owned = 4'b1111;
                  next_level[0] = 1'b0 ^ pol_ac;
                  next_level[1] = (pwm_raw && blank_count == 3'h0) ^ pol_bd;
                  next_level[2] = 1'b1 ^ pol_ac;
                  next_level[3] = 1'b0 ^ pol_bd;
               end
            endcase
         end
         st_compare: begin
            // soft-interrupt and trigger modes leave the pin to the port
            if (drives_compare_pin) begin
               next_owned = 4'b0001;
               next_level[0] = pin_q;
            end
         end
         default: begin
            next_owned = 4'b0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_level <= 4'h0;
         out_owned <= 4'h0;
      end else begin
         out_level <= next_level;
         out_owned <= next_owned;
      end
   end

   // each relocatable signal follows its own select bit
   assign out_b_location = pin_select[1] ? 2'b10 : 2'b01;
   assign out_d_location = pin_select[0] ? 2'b10 : 2'b01;

endmodule
`default_nettype wire

// ===== test/ccp_mode_output_config_properties.sv
// Purpose: port assertions for ccp_mode_output_config
// Assumes: pins settle two or three edges after a control write
// Notes: control writes are spaced so those windows never overlap
`include "ccp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ccp_mode_output_config_properties #(
   parameter bit ENHANCED = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] out_owned,
   input wire logic [1:0] out_b_location,
   input wire logic [1:0] out_d_location,
   input wire logic timer_reset,
   input wire logic adc_start,
   input wire logic adc_enabled
);
   logic wr_ctl;
   logic pwm;
   logic [3:0] md;
   logic [1:0] cf;
   assign md = pwdata[3:0];
   assign cf = pwdata[7:6];
   assign wr_ctl = psel && penable && pwrite && paddr == `ADDR_CONTROL;
   assign pwm = wr_ctl && md[3:2] == 2'h3;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready;
      pready && !pslverr;
   endproperty
   a_ready: assert property (p_ready) else $error("apb stall or error");
   property p_off;
      wr_ctl && (md == `MODE_OFF || md == `MODE_RSV1 || md == `MODE_RSV3)
         |-> ##[2:3] out_owned == 4'h0;
   endproperty
   a_off: assert property (p_off) else $error("off mode drives pins");
   property p_cmp;
      wr_ctl && (md == `MODE_TOGGLE || md == `MODE_CMP_SET || md == `MODE_CMP_CLR)
         |-> ##[2:3] out_owned == 4'h1;
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare pin set wrong");
   property p_single;
      pwm && (cf == `CFG_SINGLE || !ENHANCED) |-> ##[2:3] out_owned == 4'h1;
   endproperty
   a_single: assert property (p_single) else $error("single pin set wrong");
   property p_half;
      pwm && ENHANCED && cf == `CFG_HALF |-> ##[2:3] out_owned == 4'h3;
   endproperty
   a_half: assert property (p_half) else $error("half bridge pins wrong");
   property p_bridge;
      pwm && ENHANCED && cf[0] |-> ##[2:3] out_owned == 4'hf;
   endproperty
   a_bridge: assert property (p_bridge) else $error("full bridge pins wrong");
   property p_loc;
      $onehot(out_b_location) && $onehot(out_d_location);
   endproperty
   a_loc: assert property (p_loc) else $error("pin location not one-hot");
   property p_adc;
      adc_start |-> timer_reset && $past(adc_enabled);
   endproperty
   a_adc: assert property (p_adc) else $error("conversion start unexpected");
   property p_pulse;
      timer_reset |=> !timer_reset;
   endproperty
   a_pulse: assert property (p_pulse) else $error("timer reset too long");
endmodule
bind ccp_mode_output_config ccp_mode_output_config_properties
   #(.ENHANCED(ENHANCED)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .out_owned(out_owned), .out_b_location(out_b_location),
   .out_d_location(out_d_location), .timer_reset(timer_reset), .adc_start(adc_start),
   .adc_enabled(adc_enabled));
`default_nettype wire

// ===== test/ccp_mode_output_config_tb.sv
// Purpose: self-checking bench for ccp_mode_output_config
// Assumes: zero-wait apb slave, pins one cycle behind state
// Notes: compare matches last one cycle, as a reset timer would
`include "ccp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ccp_mode_output_config_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, seed = 8'h2a;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, pwm_period_start = 1'b0, unit_pin_in = 1'b0, adc_enabled = 1'b0;
   logic [15:0] timer_value = 16'h0;
   logic [9:0] pwm_timer = 10'h0;
   logic [3:0] port_out = 4'h0, out_level, out_owned;
   logic [1:0] out_b_location, out_d_location;
   logic timer_reset, adc_start, unit_event_flag, irq, tmr_run = 1'b0, kick = 1'b0;
   int mismatches = 0, comparisons = 0, n_rst = 0, n_adc = 0;
   ccp_mode_output_config u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .timer_value, .pwm_timer, .pwm_period_start,
      .unit_pin_in, .port_out, .adc_enabled, .out_level, .out_owned, .out_b_location,
      .out_d_location, .timer_reset, .adc_start, .unit_event_flag, .irq);
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      if (tmr_run) pwm_timer <= pwm_timer + 10'h1;
      pwm_period_start <= tmr_run ? pwm_timer[3:0] == 4'hf : kick;
      if (timer_reset) n_rst++;
      if (adc_start) n_adc++;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         give_verdict();
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic match(input logic [15:0] r);
      @(posedge pclk);
      timer_value <= r;
      @(posedge pclk);
      timer_value <= 16'h0;
      repeat (3) @(negedge pclk);
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      mismatches++;
      give_verdict();
   end
   initial begin
      logic [7:0] v;
      logic [15:0] r;
      logic [3:0] m;
      logic [1:0] c;
      logic [3:0] cm [4];
      int n;
      cm = '{`MODE_CMP_SET, `MODE_CMP_CLR, `MODE_CMP_SOFT, `MODE_TOGGLE};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`ADDR_CONTROL, {24'h0, `CONTROL_RESET});
      chk({out_b_location, out_d_location, out_owned}, 8'h50);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         v = seed;
         wr(`ADDR_CONTROL, {24'h0, v});
         rd_chk(`ADDR_CONTROL, {24'h0, v});
         wr(`ADDR_PIN_SELECT, {30'h0, v[1:0]});
         chk({out_b_location, out_d_location}, {v[1], !v[1], v[0], !v[0]});
      end
      wr(8'h20, 32'hff);
      rd_chk(8'h20, 32'h0);
      $display("registers done");
      wr(`ADDR_MASK, 32'h7);
      for (int k = 0; k < 4; k++) begin
         m = cm[k];
         seed = lfsr(seed);
         r = {seed, 8'h01};
         wr(`ADDR_CONTROL, 32'h0);
         wr(`ADDR_STATUS, 32'h7);
         wr(`ADDR_COMPARE, {16'h0, r});
         wr(`ADDR_CONTROL, {24'h0, seed[7:6], 2'h0, m});
         repeat (3) @(negedge pclk);
         v = {4'h0, out_level};
         if (m[3:1] == 3'h4) chk(out_level[0], m[0]);
         match(r);
         if (m == `MODE_CMP_SOFT) chk(out_owned[0], 1'b0);
         else chk(out_level[0], (m == `MODE_TOGGLE) ? !v[0] : !m[0]);
         chk(unit_event_flag, m != `MODE_TOGGLE);
         chk(irq, 1'b1);
         rd_chk(`ADDR_STATUS, {30'h0, 1'b1, m != `MODE_TOGGLE});
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         adc_enabled <= k[0];
         wr(`ADDR_CONTROL, {28'h0, `MODE_CMP_TRIG});
         n_rst = 0;
         n_adc = 0;
         match(r);
         chk(n_rst, 1);
         chk(n_adc, k);
         chk(unit_event_flag, 1'b1);
         wr(`ADDR_STATUS, 32'h7);
      end
      $display("compare done");
      @(posedge pclk);
      tmr_run <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         c = k[3:2];
         m = {2'h3, k[1:0]};
         wr(`ADDR_CONTROL, 32'h0);
         wr(`ADDR_CONTROL, {24'h0, c, 2'h0, m});
         repeat (20) @(negedge pclk);
         if (c == `CFG_FWD) chk(out_level[2:0], {m[1], m[0], !m[1]});
         if (c == `CFG_REV) chk({out_level[3:2], out_level[0]}, {m[0], !m[1], m[1]});
      end
      @(posedge pclk);
      tmr_run <= 1'b0;
      @(posedge pclk);
      pwm_timer <= 10'h202;
      wr(`ADDR_DUTY_HIGH, 32'h80);
      wr(`ADDR_CONTROL, 32'h3c);
      @(posedge pclk);
      kick <= 1'b1;
      @(posedge pclk);
      kick <= 1'b0;
      repeat (3) @(negedge pclk);
      chk(out_level[0], 1'b1);
      @(posedge pclk);
      tmr_run <= 1'b1;
      repeat (2) @(posedge pclk);
      tmr_run <= 1'b0;
      repeat (3) @(negedge pclk);
      chk(out_level[0], 1'b0);
      $display("pwm done");
      for (int k = 0; k < 4; k++) begin
         n = (k == 2) ? 4 : (k == 3) ? 16 : 1;
         wr(`ADDR_CONTROL, 32'h0);
         wr(`ADDR_STATUS, 32'h7);
         wr(`ADDR_CONTROL, 32'h4 + k);
         for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            unit_pin_in <= 1'b1;
            repeat (3) @(posedge pclk);
            unit_pin_in <= 1'b0;
            repeat (3) @(negedge pclk);
            chk(unit_event_flag, i == n - 1);
         end
      end
      wr(`ADDR_MASK, 32'h0);
      @(negedge pclk);
      chk(irq, 1'b0);
      wr(`ADDR_STATUS, 32'h7);
      rd_chk(`ADDR_STATUS, 32'h0);
      $display("capture done");
      give_verdict();
   end
endmodule
`default_nettype wire
